/* File: spd_core.sv */
/*
 Serial peripheral pin direction and byte shifter.
 Assumes one 100 MHz core clock; serial clock, select, MISO and MOSI inputs
 arrive from outside and are synchronised here.
*/
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_core
	import spd_pkg::*;
#(
	parameter logic [15:0] half_period = `SPD_HALF_PERIOD_DEF
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic spi_enable,
	input wire logic master_select,
	input wire logic wired_or_mode,
	input wire logic debug_break,
	input wire logic break_clear_enable,
	input wire logic data_write,
	input wire logic [7:0] write_data,
	input wire logic slave_select_n,
	input wire logic miso_in,
	input wire logic mosi_in,
	input wire logic serial_clock_pin_in,
	output logic miso_out,
	output logic miso_oe,
	output logic mosi_out,
	output logic mosi_oe,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	output logic transmit_empty_flag,
	output logic [7:0] receive_data,
	output logic receive_done,
	output logic busy
);
	logic rst_s1_reg, rst_sync_n;
	logic [3:0] s1_reg, s2_reg;
	logic sck_old_reg;
	logic ss_n_s, miso_s, mosi_s, sck_s, sck_rise, sck_fall, is_slave;
	spd_state_type state_reg, state_next;
	logic [15:0] div_reg, div_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next, rx_reg, rx_next;
	logic tef_reg, tef_next, done_reg, done_next, sck_reg, sck_next;
	logic [7:0] txd_reg, txd_next;
	logic so_reg, so_next, mo_reg, mo_next, mso_reg, mso_next;
	logic moe_reg, moe_next, soe_reg, soe_next, cko_reg, cko_next;
	logic ld_ok, tick;
	logic smp_reg, smp_next, busy_reg, busy_next;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_sync_n <= rst_s1_reg;
		end
	end

	// Two flops on serial clock, select, MISO and MOSI pins, same latency
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			s1_reg <= `SPD_PIN_IDLE;
			s2_reg <= `SPD_PIN_IDLE;
			sck_old_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= {serial_clock_pin_in, slave_select_n,
				miso_in, mosi_in};
			s2_reg <= s1_reg;
			sck_old_reg <= sck_s;
		end
	end

	// Decoded pin views
	assign ss_n_s = s2_reg[`SPD_PIN_SS];
	assign miso_s = s2_reg[`SPD_PIN_MISO];
	assign mosi_s = s2_reg[`SPD_PIN_MOSI];
	assign sck_s = s2_reg[`SPD_PIN_SCK];
	assign sck_rise = sck_s & ~sck_old_reg;
	assign sck_fall = ~sck_s & sck_old_reg;
	assign is_slave = spi_enable & ~master_select & ~ss_n_s;
	assign tick = (div_reg == 16'h0000);
	assign ld_ok = !(debug_break && !break_clear_enable);

	// Transfer sequencer, divider and pin drivers
	always_comb
	begin
		state_next = state_reg;
		div_next = tick ? half_period - 16'h0001 : div_reg - 16'h0001;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		rx_next = rx_reg;
		tef_next = tef_reg;
		txd_next = txd_reg;
		done_next = 1'b0;
		sck_next = sck_reg;
		smp_next = smp_reg;
		if (data_write && tef_reg && ld_ok)
		begin
			txd_next = write_data;
			tef_next = 1'b0;
		end
		if (!spi_enable)
		begin
			state_next = spd_idle;
			sck_next = 1'b0;
			tef_next = 1'b1;
		end
		else
		begin
			unique case (state_reg)
				spd_idle:
				begin
					if (!tef_next && (master_select || is_slave))
					begin
						sh_next = txd_next;
						tef_next = 1'b1;
						cnt_next = `SPD_BIT_ZERO;
						div_next = half_period - 16'h0001;
						state_next = spd_lead;
					end
				end
				spd_lead:
				begin
					// Sample edge: master rise of own clock, slave rise of pin
					if (master_select ? tick : sck_rise)
					begin
						smp_next = master_select ? miso_s : mosi_s;
						sck_next = master_select;
						state_next = spd_trail;
					end
				end
				spd_trail:
				begin
					if (master_select ? tick : sck_fall)
					begin
						// Shift on the fall so data holds across the rise
						sh_next = {sh_reg[6:0], smp_reg};
						sck_next = 1'b0;
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg == 4'(`SPD_BITS_PER_XFER - 1))
						begin
							rx_next = sh_next;
							done_next = 1'b1;
							state_next = spd_idle;
						end
						else
							state_next = spd_lead;
					end
				end
			endcase
		end
		// Directions owned by the block while enabled
		mo_next = sh_next[`SPD_MSB];
		moe_next = spi_enable && master_select &&
			(!wired_or_mode || !sh_next[`SPD_MSB]);
		if (wired_or_mode)
			mo_next = 1'b0;
		so_next = sh_next[`SPD_MSB];
		soe_next = spi_enable && !master_select && !ss_n_s;
		cko_next = spi_enable && master_select;
		mso_next = sck_next;
		busy_next = (state_next != spd_idle);
	end

	// State registers
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_reg <= spd_idle;
			div_reg <= 16'h0000;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			rx_reg <= 8'h00;
			tef_reg <= 1'b1;
			txd_reg <= 8'h00;
			done_reg <= 1'b0;
			sck_reg <= 1'b0;
			so_reg <= 1'b0;
			mo_reg <= 1'b0;
			mso_reg <= 1'b0;
			moe_reg <= 1'b0;
			soe_reg <= 1'b0;
			cko_reg <= 1'b0;
			smp_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			div_reg <= div_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			rx_reg <= rx_next;
			tef_reg <= tef_next;
			txd_reg <= txd_next;
			done_reg <= done_next;
			sck_reg <= sck_next;
			so_reg <= so_next;
			mo_reg <= mo_next;
			mso_reg <= mso_next;
			moe_reg <= moe_next;
			soe_reg <= soe_next;
			cko_reg <= cko_next;
			smp_reg <= smp_next;
			busy_reg <= busy_next;
		end
	end

	// Outputs straight from flops
	assign miso_out = so_reg;
	assign miso_oe = soe_reg;
	assign mosi_out = mo_reg;
	assign mosi_oe = moe_reg;
	assign serial_clock_pin_out = mso_reg;
	assign serial_clock_pin_oe = cko_reg;
	assign transmit_empty_flag = tef_reg;
	assign receive_data = rx_reg;
	assign receive_done = done_reg;
	assign busy = busy_reg;

	property p_miso_slave_only;
		@(posedge core_clk) disable iff (!rst_sync_n)
		miso_oe |-> $past(spi_enable) && !$past(master_select);
	endproperty
	a_miso_slave_only: assert property (p_miso_slave_only)
		else $error("MISO driven while not slave");

	property p_miso_hiz;
		@(posedge core_clk) disable iff (!rst_sync_n)
		ss_n_s |=> !miso_oe;
	endproperty
	a_miso_hiz: assert property (p_miso_hiz)
		else $error("MISO driven with select high");

	property p_sck_dir;
		@(posedge core_clk) disable iff (!rst_sync_n)
		spi_enable && master_select |=> serial_clock_pin_oe;
	endproperty
	a_sck_dir: assert property (p_sck_dir)
		else $error("Master serial clock not driven");

	property p_disabled_release;
		@(posedge core_clk) disable iff (!rst_sync_n)
		!spi_enable |=> !mosi_oe && !miso_oe && !serial_clock_pin_oe;
	endproperty
	a_disabled_release: assert property (p_disabled_release)
		else $error("Pin driven while disabled");

	property p_byte_len;
		@(posedge core_clk) disable iff (!rst_sync_n)
		receive_done |-> $past(cnt_reg) == 4'(`SPD_BITS_PER_XFER - 1);
	endproperty
	a_byte_len: assert property (p_byte_len)
		else $error("Transfer not eight clocks");

	property p_wom;
		@(posedge core_clk) disable iff (!rst_sync_n)
		$past(wired_or_mode) |-> !mosi_out;
	endproperty
	a_wom: assert property (p_wom)
		else $error("MOSI driven high in wired-or mode");

	property p_break_block;
		@(posedge core_clk) disable iff (!rst_sync_n)
		tef_reg && !ld_ok && spi_enable |=> tef_reg;
	endproperty
	a_break_block: assert property (p_break_block)
		else $error("Write in break took effect");

	property p_master_shift;
		@(posedge core_clk) disable iff (!rst_sync_n)
		state_reg == spd_lead && master_select && tick && spi_enable
		|=> smp_reg == $past(miso_s);
	endproperty
	a_master_shift: assert property (p_master_shift)
		else $error("Master did not sample MISO");

	c_done: cover property (@(posedge core_clk) receive_done);
	c_slave: cover property (@(posedge core_clk) miso_oe && busy);
	c_wom: cover property (@(posedge core_clk) wired_or_mode && busy);
endmodule

/* File: spd_pkg.sv */
/*
 Types for the serial pin direction block.
 Assumes spd_regs.svh sits in the same folder.
*/
`include "spd_regs.svh"
package spd_pkg;
typedef enum logic [1:0] {
	spd_idle,
	spd_lead,
	spd_trail
} spd_state_type;
endpackage

/* File: spd_regs.svh */
/*
 Constants for the serial pin direction block: shift length, pin sync
 layout and idle levels, clock divider default and bit positions.
 Assumes inclusion by the package and the design module only.
*/
// Summary of operation
// - Drive slave data on MISO only when not master and select low
// - Select high puts MISO into high impedance for shared slaves
// - While enabled, block sets MISO, MOSI, serial clock directions itself
// - Master drives serial clock out; slave takes it as input
// - One byte per transfer, exactly eight serial clock cycles
// - Master shifts out on MOSI on the serial clock fall and samples MISO on the rise
// - Wired-or mode makes MOSI open drain instead of push-pull
// - Break with clear disabled: data write starts nothing, loads nothing
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH
// Pin sync layout {serial clock, select, MISO, MOSI}; clock idles low
`define SPD_PIN_IDLE 4'h7
`define SPD_PIN_SCK 3
`define SPD_PIN_SS 2
`define SPD_PIN_MISO 1
`define SPD_PIN_MOSI 0
`define SPD_BITS_PER_XFER 8
`define SPD_HALF_PERIOD_DEF 16'h0004
`define SPD_MSB 3'h7
`define SPD_BIT_ZERO 4'h0
`endif

/* File: spd_slave_model.sv */
/*
 Behavioural far-side slave for the serial pin block: idle-low clock,
 sample on rising edge, shift on falling edge, MSB first.
 Assumes the bench resolves the shared lines before they reach it.
*/
`timescale 1ns/1ps
module spd_slave_model
(
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	logic [7:0] sh;
	// Start idle
	initial
	begin
		miso = 1'b0;
		rx_byte = 8'h00;
		sh = 8'h00;
	end
	// Present the top reply bit as select falls
	always @(negedge ss_n)
	begin
		sh = tx_byte;
		miso = tx_byte[7];
	end
	// Take one bit per rising clock
	always @(posedge sck)
		if (!ss_n)
			rx_byte = {rx_byte[6:0], mosi};
	// Next reply bit on the falling clock
	always @(negedge sck)
		if (!ss_n)
		begin
			sh = {sh[6:0], 1'b0};
			miso = sh[7];
		end
	// Released line must not keep the last value
	always @(posedge ss_n)
		miso = ~miso;
endmodule

/* File: test_spi_pin_direction_control.sv */
/*
 Self-checking bench for the serial pin block: master exchanges in both
 output modes, blocked writes in break, and slave operation.
 Assumes spd_core, spd_pkg and spd_slave_model are compiled first.
*/
`timescale 1ns/1ps
module test_spi_pin_direction_control;
	import spd_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, en = 1'b0, ms = 1'b1, wom = 1'b0;
	logic dbg = 1'b0, bce = 1'b0, wr = 1'b0, d_ss_n = 1'b1, m_ss_n = 1'b1;
	logic bm_mosi = 1'b1, bm_sck = 1'b0;
	logic [7:0] wd = 8'h00, m_tx = 8'h00, rx = 8'h00;
	logic miso_out, miso_oe, mosi_out, mosi_oe, sck_out, sck_oe, tef;
	logic rdone, busy, m_miso, miso_l, mosi_l, sck_l;
	logic [7:0] rd, m_rx;
	logic [15:0] seed;
	int err_total = 0, num_checks = 0, sck_edges = 0;

	spd_core #(.half_period(16'h0004)) dut_u (.core_clk(core_clk),
		.rst_n(rst_n), .spi_enable(en), .master_select(ms),
		.wired_or_mode(wom), .debug_break(dbg), .break_clear_enable(bce),
		.data_write(wr), .write_data(wd), .slave_select_n(d_ss_n),
		.miso_in(miso_l), .mosi_in(mosi_l), .serial_clock_pin_in(sck_l),
		.miso_out(miso_out), .miso_oe(miso_oe), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .serial_clock_pin_out(sck_out),
		.serial_clock_pin_oe(sck_oe), .transmit_empty_flag(tef),
		.receive_data(rd), .receive_done(rdone), .busy(busy));
	spd_slave_model model_u (.sck(sck_l), .ss_n(m_ss_n), .mosi(mosi_l),
		.tx_byte(m_tx), .miso(m_miso), .rx_byte(m_rx));

	// Clock and resolved lines; undriven MOSI and clock come from the bench, undriven MISO from the slave model
	always #5 core_clk = ~core_clk;
	assign mosi_l = mosi_oe ? mosi_out : bm_mosi;
	assign sck_l = sck_oe ? sck_out : bm_sck;
	assign miso_l = miso_oe ? miso_out : m_miso;
	always @(posedge sck_l) sck_edges++;

	// Output mode watch while the master shifts
	always @(negedge core_clk)
		if (wom === 1'b1 && mosi_oe === 1'b1)
			chk(8'h00, {7'h0, mosi_out});
		else if (busy === 1'b1 && ms === 1'b1 && wom === 1'b0)
			chk(8'h01, {7'h0, mosi_oe});

	function automatic logic [15:0] xs(input logic [15:0] x);
		logic [15:0] y;
		y = x ^ (x << 7);
		y = y ^ (y >> 9);
		return y ^ (y << 8);
	endfunction

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch at %0t exp %h got %h", $time, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic put(input logic [7:0] d);
		wd = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		while (rdone !== 1'b1 && n < 300)
		begin
			tick(1);
			n++;
		end
		chk(8'h01, {7'h0, rdone});
	endtask

	// One master exchange against the slave model
	task automatic mxfer(input logic [7:0] d, input logic [7:0] s);
		m_tx = s;
		tick(1);
		m_ss_n = 1'b0;
		sck_edges = 0;
		tick(2);
		put(d);
		tick(1);
		chk(8'h03, {5'h0, miso_oe, sck_oe, mosi_oe | wom});
		wait_done();
		chk(8'h08, sck_edges[7:0]);
		chk(s, rd);
		chk(d, m_rx);
		m_ss_n = 1'b1;
		tick(2);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#50000;
		err_total++;
		final_report();
	end

	// Main sequence
	initial
	begin
		seed = 16'hcfd5;
		tick(6);
		rst_n = 1'b1;
		tick(3);
		en = 1'b1;
		tick(2);
		for (int i = 0; i < 8; i++)
		begin
			wom = i[2];
			seed = xs(seed);
			mxfer(i[0] ? seed[7:0] : {8{i[1]}}, seed[15:8]);
		end
		$display("test master done");
		dbg = 1'b1;
		put(8'h5a);
		tick(2);
		chk(8'h01, {6'h0, busy, tef});
		bce = 1'b1;
		mxfer(8'ha5, 8'h3c);
		dbg = 1'b0;
		bce = 1'b0;
		$display("test break done");
		ms = 1'b0;
		tick(4);
		chk(8'h00, {6'h0, miso_oe, sck_oe});
		d_ss_n = 1'b0;
		tick(4);
		chk(8'h02, {6'h0, miso_oe, sck_oe});
		seed = xs(seed);
		put(seed[7:0]);
		tick(4);
		for (int b = 7; b >= 0; b--)
		begin
			bm_sck = 1'b0;
			bm_mosi = seed[8 + b];
			#62.5 bm_sck = 1'b1;
			rx = {rx[6:0], miso_l};
			#62.5;
		end
		bm_sck = 1'b0;
		wait_done();
		chk(seed[15:8], rd);
		chk(seed[7:0], rx);
		d_ss_n = 1'b1;
		tick(4);
		chk(8'h00, {7'h0, miso_oe});
		$display("test slave done");
		final_report();
	end
endmodule
